// >>> psq_pkg.sv
// Package of constants and types for the port mode sequencer
package psq_pkg;

  localparam int          NPORT_DEF    = 8;
  localparam int          ADDR_W       = 8;

  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_STRAP    = 8'h04;
  localparam logic [7:0]  OFF_MODE     = 8'h08;
  localparam logic [7:0]  OFF_ENAB     = 8'h0c;
  localparam logic [7:0]  OFF_CMD      = 8'h10;
  localparam logic [7:0]  OFF_PWR      = 8'h14;
  localparam logic [7:0]  OFF_RES0     = 8'h20;
  localparam logic [7:0]  OFF_RES_END  = 8'h40;

  localparam int          CTRL_SOFT    = 0;
  localparam int          CTRL_HP      = 1;
  localparam int          CTRL_EXT     = 2;
  localparam int          ENAB_DET     = 0;
  localparam int          ENAB_CLS     = 8;
  localparam int          ENAB_DIS     = 16;
  localparam int          CMD_DET      = 0;
  localparam int          CMD_CLS      = 8;
  localparam int          CMD_ON       = 16;
  localparam int          CMD_OFF      = 24;

  localparam int          PIN_RSTN     = 0;
  localparam int          PIN_AUTO     = 1;
  localparam int          PIN_MID      = 2;
  localparam int          PIN_PLO      = 3;
  localparam int          PIN_PHI      = 4;
  localparam logic [4:0]  PIN_RST_VAL  = 5'h01;

  typedef enum logic [1:0] {
    MD_SHUT   = 2'b00,
    MD_MANUAL = 2'b01,
    MD_SEMI   = 2'b10,
    MD_AUTO   = 2'b11
  } psq_mode_t;

  typedef enum logic [1:0] {
    MK_FCUR   = 2'b00,
    MK_FVOLT  = 2'b01,
    MK_CLASS  = 2'b10
  } psq_kind_t;

  typedef enum logic [2:0] {
    DR_UNKNOWN = 3'h0,
    DR_SHORT   = 3'h1,
    DR_LOW     = 3'h2,
    DR_GOOD    = 3'h3,
    DR_HIGH    = 3'h4,
    DR_OPEN    = 3'h5
  } psq_det_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DETI   = 3'b001,
    ST_DETV   = 3'b011,
    ST_CLASS  = 3'b010,
    ST_WAIT   = 3'b110,
    ST_ON     = 3'b111
  } psq_state_t;

  // Resistance in units of 100 ohm
  localparam logic [10:0] R_SHORT      = 11'h018;
  localparam logic [10:0] R_LOW        = 11'h0aa;
  localparam logic [10:0] R_HIGH       = 11'h122;
  localparam logic [10:0] R_OPEN       = 11'h1f4;

  // Power in units of 0.1 W
  localparam logic [9:0]  PWR_L0       = 10'h183;
  localparam logic [9:0]  PWR_L1       = 10'h20f;
  localparam logic [9:0]  PWR_L2       = 10'h2bc;
  localparam logic [9:0]  PWR_L3       = 10'h384;
  localparam logic [9:0]  PWR_STD      = 10'h0ff;
  localparam logic [9:0]  PWR_ANY      = 10'h3ff;

  // Thresholds in mA
  localparam logic [9:0]  ICUT_C1      = 10'h070;
  localparam logic [9:0]  ICUT_C2      = 10'h0ce;
  localparam logic [9:0]  ICUT_C3      = 10'h177;
  localparam logic [9:0]  ICUT_C4      = 10'h27e;
  localparam logic [9:0]  ILIM_STD     = 10'h1a9;
  localparam logic [9:0]  ILIM_C4      = 10'h352;

  localparam int          CLK_KHZ      = 40000;
  localparam int          BACKOFF_MS   = 100;
  localparam int          MID_BACK_MS  = 2000;

endpackage : psq_pkg

// >>> psq_top.sv
// Eight-port mode sequencer with APB registers and shared measurement
`timescale 1ns/1ps
// Notes on behaviour
// - Eight ports, each in its own mode
// - Mode code 11 auto, 10 semi, 01 manual, 00 off
// - Manual: one cycle per command, host powers
// - Semi: repeat detect and class, host powers
// - Auto: like semi, powers and sets thresholds
// - Auto only while standalone pin high throughout
// - Shutdown: no detection, never powered
// - Current limit fault always removes power
// - Disconnect removes power when enabled
// - Reset by pin, power-up, soft bit; pin or soft reset captures straps, power-up takes them as low
// - Later strap changes ignored until pin or soft reset, except standalone pin going low
// - Standalone strap configures all ports automatic
// - Auto thresholds chosen by class table
// - Class thresholds only with standalone strap
// - Extended power needs both enable bits
// - Power limit pins pick maximum power, with standalone strap only
// - Never power device above maximum level, except by manual command
// - Forced current first, then forced voltage
// - Valid only when both measurements valid
// - 17k to 29k reported as good
// - First reading below 1V aborts as short
// - Reset pin low keeps ports off, defaults
// - Backoff 100ms, or 2s in midspan
module psq_top #(
  parameter int NPORT           = psq_pkg::NPORT_DEF,
  parameter int CNT_W           = 27,
  parameter int BACKOFF_CYC     = psq_pkg::BACKOFF_MS * psq_pkg::CLK_KHZ,
  parameter int MID_BACKOFF_CYC = psq_pkg::MID_BACK_MS * psq_pkg::CLK_KHZ
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [psq_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic                   reset_pin_n_i,
  input  wire logic                   standalone_sel_i,
  input  wire logic                   midspan_sel_i,
  input  wire logic                   power_limit_select_lo_i,
  input  wire logic                   power_limit_select_hi_i,
  input  wire logic [NPORT-1:0]       port_ilim_fault_i,
  input  wire logic [NPORT-1:0]       port_disconnect_i,
  output logic                        meas_req_o,
  output logic      [2:0]             meas_port_o,
  output psq_pkg::psq_kind_t          meas_kind_o,
  input  wire logic                   meas_done_i,
  input  wire logic                   meas_short_i,
  input  wire logic [10:0]            meas_res_i,
  input  wire logic [2:0]             meas_class_i,
  input  wire logic [9:0]             meas_pwr_i,
  output logic      [NPORT-1:0]       port_output_pin_o,
  output logic      [10*NPORT-1:0]    port_icut_ma_o,
  output logic      [10*NPORT-1:0]    port_ilim_ma_o,
  output logic                        ext_power_en_o
);
  import psq_pkg::*;

  if (NPORT < 1 || NPORT > 8) begin : g_bad_nport
    $error("NPORT must lie between 1 and 8");
  end
  if (MID_BACKOFF_CYC >= (2 ** CNT_W) || BACKOFF_CYC < 1) begin : g_bad_cnt
    $error("Backoff counts do not fit CNT_W");
  end

  localparam logic [CNT_W-1:0] BO_LIM  = CNT_W'(BACKOFF_CYC - 1);
  localparam logic [CNT_W-1:0] MBO_LIM = CNT_W'(MID_BACKOFF_CYC - 1);

  function automatic psq_det_t det_code(input logic [10:0] r);
    if (r < R_SHORT) begin
      det_code = DR_SHORT;
    end else if (r < R_LOW) begin
      det_code = DR_LOW;
    end else if (r <= R_HIGH) begin
      det_code = DR_GOOD;
    end else if (r <= R_OPEN) begin
      det_code = DR_HIGH;
    end else begin
      det_code = DR_OPEN;
    end
  endfunction : det_code

  // Pin synchronisers and agreement filter
  logic [4:0]             pin_raw;
  logic [4:0]             pin_s1_q;
  logic [4:0]             pin_s2_q;
  logic [4:0]             pin_s3_q;
  logic [4:0]             pin_q;

  assign pin_raw = {power_limit_select_hi_i, power_limit_select_lo_i,
                    midspan_sel_i, standalone_sel_i, reset_pin_n_i};

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {pin_s1_q, pin_s2_q, pin_s3_q, pin_q} <= {4{PIN_RST_VAL}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int b = 0; b < 5; b++) begin
        if (pin_s2_q[b] == pin_s3_q[b]) begin
          pin_q[b] <= pin_s2_q[b];
        end
      end
    end
  end

  // Internal reset and strap capture
  logic                   soft_rst_q;
  logic                   int_rst;
  logic                   strap_ok_q;
  logic                   auto_strap_q;
  logic                   mid_strap_q;
  logic [9:0]             max_pwr_q;

  assign int_rst = !pin_q[PIN_RSTN] || soft_rst_q;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {strap_ok_q, auto_strap_q, mid_strap_q} <= '0;
      max_pwr_q    <= PWR_ANY;
    end else if (int_rst) begin
      strap_ok_q   <= 1'b0;
    end else if (!strap_ok_q) begin
      strap_ok_q   <= 1'b1;
      auto_strap_q <= pin_q[PIN_AUTO];
      mid_strap_q  <= pin_q[PIN_MID];
      if (!pin_q[PIN_AUTO]) begin
        max_pwr_q <= PWR_ANY;
      end else begin
        case ({pin_q[PIN_PHI], pin_q[PIN_PLO]})
          2'b00:   max_pwr_q <= PWR_L0;
          2'b01:   max_pwr_q <= PWR_L1;
          2'b10:   max_pwr_q <= PWR_L2;
          default: max_pwr_q <= PWR_L3;
        endcase
      end
    end
  end

  // Register file
  logic                   hp_en_q;
  logic                   ext_bit_q;
  logic [2*NPORT-1:0]     mode_q;
  logic [NPORT-1:0]       den_q;
  logic [NPORT-1:0]       cen_q;
  logic [NPORT-1:0]       disen_q;
  logic [NPORT-1:0]       cmd_det_q;
  logic [NPORT-1:0]       cmd_cls_q;
  logic [NPORT-1:0]       cmd_on_q;
  logic [NPORT-1:0]       cmd_off_q;
  logic                   wr_go;
  logic [NPORT-1:0]       all_one;
  logic [9:0]             pwr_lim;

  assign wr_go   = psel_i && penable_i && pready_o && pwrite_i;
  assign all_one = {NPORT{1'b1}};
  assign pwr_lim = (hp_en_q && ext_bit_q) ? max_pwr_q :
                   ((max_pwr_q < PWR_STD) ? max_pwr_q : PWR_STD);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_go && paddr_i == OFF_CTRL && pwdata_i[CTRL_SOFT];
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {hp_en_q, ext_bit_q, mode_q, den_q, cen_q, disen_q} <= '0;
    end else if (int_rst) begin
      {hp_en_q, ext_bit_q, mode_q, den_q, cen_q, disen_q} <= '0;
    end else if (!strap_ok_q) begin
      if (pin_q[PIN_AUTO]) begin
        mode_q  <= {NPORT{MD_AUTO}};
        den_q   <= all_one;
        cen_q   <= all_one;
        disen_q <= all_one;
        hp_en_q <= 1'b1;
      end
    end else if (wr_go) begin
      case (paddr_i)
        OFF_CTRL: begin
          hp_en_q   <= pwdata_i[CTRL_HP];
          ext_bit_q <= pwdata_i[CTRL_EXT];
        end
        OFF_MODE: mode_q <= pwdata_i[2*NPORT-1:0];
        OFF_ENAB: begin
          den_q   <= pwdata_i[ENAB_DET+:NPORT];
          cen_q   <= pwdata_i[ENAB_CLS+:NPORT];
          disen_q <= pwdata_i[ENAB_DIS+:NPORT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {cmd_det_q, cmd_cls_q, cmd_on_q, cmd_off_q} <= '0;
    end else if (wr_go && paddr_i == OFF_CMD && !int_rst) begin
      cmd_det_q <= pwdata_i[CMD_DET+:NPORT];
      cmd_cls_q <= pwdata_i[CMD_CLS+:NPORT];
      cmd_on_q  <= pwdata_i[CMD_ON+:NPORT];
      cmd_off_q <= pwdata_i[CMD_OFF+:NPORT];
    end else begin
      {cmd_det_q, cmd_cls_q, cmd_on_q, cmd_off_q} <= '0;
    end
  end

  // Port state
  psq_state_t             st_q   [NPORT];
  psq_det_t               res_q  [NPORT];
  logic [2:0]             cls_q  [NPORT];
  logic [9:0]             preq_q [NPORT];
  logic [CNT_W-1:0]       bo_q   [NPORT];
  logic [NPORT-1:0]       want;
  psq_kind_t              kind   [NPORT];
  logic [NPORT-1:0]       done_v;

  // APB read path, one wait state
  logic [31:0]            rdata;
  logic                   rd_bad;
  logic [2:0]             ridx;

  assign ridx = paddr_i[4:2];

  always_comb begin
    rdata  = '0;
    rd_bad = 1'b0;
    case (paddr_i)
      OFF_CTRL:  rdata = {29'h0, ext_bit_q, hp_en_q, 1'b0};
      OFF_STRAP: rdata = {18'h0, max_pwr_q, 1'b0, strap_ok_q,
                          mid_strap_q, auto_strap_q};
      OFF_MODE:  rdata[2*NPORT-1:0] = mode_q;
      OFF_ENAB: begin
        rdata[ENAB_DET+:NPORT] = den_q;
        rdata[ENAB_CLS+:NPORT] = cen_q;
        rdata[ENAB_DIS+:NPORT] = disen_q;
      end
      OFF_CMD:   rdata = '0;
      OFF_PWR:   rdata[NPORT-1:0] = port_output_pin_o;
      default: begin
        if (paddr_i >= OFF_RES0 && paddr_i < OFF_RES_END &&
            paddr_i[1:0] == 2'b00 && 32'(ridx) < NPORT) begin
          rdata = {14'h0, preq_q[ridx], 1'b0, cls_q[ridx], 1'b0,
                   res_q[ridx]};
        end else begin
          rd_bad = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {pready_o, pslverr_o, prdata_o} <= '0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o  <= 1'b1;
      prdata_o  <= pwrite_i ? 32'h0 : rdata;
      pslverr_o <= rd_bad;
    end else begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Shared measurement engine arbiter
  logic [2:0]             rr_q;
  logic                   pick_v;
  logic [2:0]             pick;
  logic [2:0]             cand;

  always_comb begin
    pick_v = 1'b0;
    pick   = '0;
    cand   = '0;
    for (int k = 0; k < 8; k++) begin
      cand = 3'(rr_q + 3'(k));
      if (!pick_v && 32'(cand) < NPORT && want[cand]) begin
        pick_v = 1'b1;
        pick   = cand;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {meas_req_o, meas_port_o, rr_q} <= '0;
      meas_kind_o <= MK_FCUR;
    end else if (meas_req_o) begin
      if (meas_done_i) begin
        meas_req_o <= 1'b0;
      end
    end else if (pick_v && !int_rst) begin
      meas_req_o  <= 1'b1;
      meas_port_o <= pick;
      meas_kind_o <= kind[pick];
      rr_q        <= 3'(pick + 3'h1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_power_en_o <= 1'b0;
    end else begin
      ext_power_en_o <= hp_en_q && ext_bit_q;
    end
  end

  // One identical machine per port
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    psq_mode_t   mode;
    logic        auto_ok;
    logic        shut;
    logic        fin_auto;
    logic        may_on;

    assign mode    = psq_mode_t'(mode_q[2*i+:2]);
    assign auto_ok = mode == MD_AUTO && auto_strap_q && pin_q[PIN_AUTO];
    assign shut    = mode == MD_SHUT || (mode == MD_AUTO && !auto_ok) ||
                     !strap_ok_q;
    assign done_v[i] = meas_req_o && meas_done_i && meas_port_o == 3'(i);
    assign want[i] = (st_q[i] == ST_DETI || st_q[i] == ST_DETV ||
                      st_q[i] == ST_CLASS) && !shut &&
                     !(meas_req_o && meas_port_o == 3'(i));
    assign kind[i] = st_q[i] == ST_DETI ? MK_FCUR :
                     st_q[i] == ST_DETV ? MK_FVOLT : MK_CLASS;
    assign may_on  = preq_q[i] <= pwr_lim;
    assign fin_auto = mode == MD_AUTO;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        st_q[i]   <= ST_IDLE;
        res_q[i]  <= DR_UNKNOWN;
        cls_q[i]  <= '0;
        preq_q[i] <= '0;
        bo_q[i]   <= '0;
        port_output_pin_o[i] <= 1'b0;
        port_icut_ma_o[10*i+:10] <= '0;
        port_ilim_ma_o[10*i+:10] <= '0;
      end else if (int_rst || shut) begin
        st_q[i]   <= ST_IDLE;
        if (int_rst) begin
          res_q[i]  <= DR_UNKNOWN;
          cls_q[i]  <= '0;
          preq_q[i] <= '0;
        end
        port_output_pin_o[i] <= 1'b0;
      end else begin
        case (st_q[i])
          ST_IDLE, ST_WAIT: begin
            if (cmd_on_q[i] && (mode == MD_MANUAL ||
                (res_q[i] == DR_GOOD && may_on))) begin
              st_q[i] <= ST_ON;
              port_output_pin_o[i] <= 1'b1;
            end else if (st_q[i] == ST_WAIT) begin
              if (bo_q[i] == (mid_strap_q ? MBO_LIM : BO_LIM)) begin
                st_q[i] <= ST_IDLE;
              end else begin
                bo_q[i] <= CNT_W'(bo_q[i] + 1'b1);
              end
            end else if (mode == MD_MANUAL) begin
              if (cmd_det_q[i]) begin
                st_q[i] <= ST_DETI;
                cls_q[i] <= '0;
              end else if (cmd_cls_q[i]) begin
                st_q[i] <= ST_CLASS;
              end
            end else if (den_q[i]) begin
              st_q[i]  <= ST_DETI;
              cls_q[i] <= '0;
              preq_q[i] <= '0;
            end
          end
          ST_DETI: begin
            if (done_v[i]) begin
              if (meas_short_i) begin
                res_q[i] <= DR_SHORT;
              end else begin
                res_q[i] <= det_code(meas_res_i);
              end
              if (!meas_short_i && det_code(meas_res_i) == DR_GOOD) begin
                st_q[i] <= ST_DETV;
              end else begin
                st_q[i] <= mode == MD_MANUAL ? ST_IDLE : ST_WAIT;
                bo_q[i] <= '0;
              end
            end
          end
          ST_DETV: begin
            if (done_v[i]) begin
              res_q[i] <= det_code(meas_res_i);
              bo_q[i]  <= '0;
              if (det_code(meas_res_i) != DR_GOOD ||
                  mode == MD_MANUAL) begin
                st_q[i] <= mode == MD_MANUAL ? ST_IDLE : ST_WAIT;
              end else if (cen_q[i]) begin
                st_q[i] <= ST_CLASS;
              end else if (fin_auto && may_on) begin
                st_q[i] <= ST_ON;
                port_output_pin_o[i] <= 1'b1;
                port_icut_ma_o[10*i+:10] <= ICUT_C3;
                port_ilim_ma_o[10*i+:10] <= ILIM_STD;
              end else begin
                st_q[i] <= ST_WAIT;
              end
            end
          end
          ST_CLASS: begin
            if (done_v[i]) begin
              cls_q[i]  <= meas_class_i;
              preq_q[i] <= meas_pwr_i;
              bo_q[i]   <= '0;
              if (mode == MD_MANUAL) begin
                st_q[i] <= ST_IDLE;
              end else if (fin_auto && meas_pwr_i <= pwr_lim) begin
                st_q[i] <= ST_ON;
                port_output_pin_o[i] <= 1'b1;
                case (meas_class_i)
                  3'h1: port_icut_ma_o[10*i+:10] <= ICUT_C1;
                  3'h2: port_icut_ma_o[10*i+:10] <= ICUT_C2;
                  3'h4: port_icut_ma_o[10*i+:10] <= ICUT_C4;
                  default: port_icut_ma_o[10*i+:10] <= ICUT_C3;
                endcase
                port_ilim_ma_o[10*i+:10] <= meas_class_i == 3'h4 ?
                                            ILIM_C4 : ILIM_STD;
              end else begin
                st_q[i] <= ST_WAIT;
              end
            end
          end
          ST_ON: begin
            if (port_ilim_fault_i[i] || cmd_off_q[i] ||
                (port_disconnect_i[i] && disen_q[i])) begin
              port_output_pin_o[i] <= 1'b0;
              st_q[i] <= mode == MD_MANUAL ? ST_IDLE : ST_WAIT;
              bo_q[i] <= '0;
            end
          end
          default: st_q[i] <= ST_IDLE;
        endcase
      end
    end
  end

endmodule : psq_top

// >>> psq_top_sva.sv
// Assertion checker for the port mode sequencer
`timescale 1ns/1ps
module psq_top_sva
  import psq_pkg::*;
#(
  parameter int NPORT = 8
) (
  input wire logic              clk_sys_i,
  input wire logic              sys_rst_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              reset_pin_n_i,
  input wire logic [NPORT-1:0]  port_ilim_fault_i,
  input wire logic              meas_req_o,
  input wire logic [2:0]        meas_port_o,
  input wire psq_kind_t         meas_kind_o,
  input wire logic              meas_done_i,
  input wire logic [NPORT-1:0]  port_output_pin_o,
  input wire logic              ext_power_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_ilim_off;
    |(port_output_pin_o & port_ilim_fault_i) |=>
      ~|(port_output_pin_o & $past(port_output_pin_o & port_ilim_fault_i));
  endproperty
  a_ilim_off: assert property (p_ilim_off) else $error("power kept");
  property p_req_hold;
    disable iff (sys_rst_i || !reset_pin_n_i)
    meas_req_o && !meas_done_i |=>
      meas_req_o && $stable(meas_port_o) && $stable(meas_kind_o);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req moved");
  property p_req_drop;
    meas_req_o && meas_done_i |=> !meas_req_o;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("req kept");
  property p_pin_off;
    !reset_pin_n_i [*8] |-> port_output_pin_o == '0;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("port on");
  property p_pin_idle;
    !reset_pin_n_i [*8] ##1 !reset_pin_n_i [*4] |-> !meas_req_o;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("measuring");
  property p_ext_en;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFF_CTRL
      |-> ##[1:2] ext_power_en_o == $past(pwdata_i[1] & pwdata_i[2]);
  endproperty
  a_ext_en: assert property (p_ext_en) else $error("ext enable");
  property p_apb_wait;
    psel_i && !penable_i |=> !pready_o ##1 pready_o;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait");
  property p_unmapped;
    psel_i && penable_i && pready_o && !pwrite_i && paddr_i == 8'h18
      |-> pslverr_o && prdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  c_fault: cover property (|(port_output_pin_o & port_ilim_fault_i));
  c_meas: cover property (meas_req_o && meas_done_i);
  c_ext: cover property (ext_power_en_o);
endmodule : psq_top_sva
bind psq_top psq_top_sva #(.NPORT(NPORT)) i_psq_top_sva (.*);

// >>> psq_meas_model.sv
// Measurement engine and cable load model
`timescale 1ns/1ps
module psq_meas_model
  import psq_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        meas_req_i,
  input  wire psq_kind_t   meas_kind_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        short_i,
  input  wire logic [10:0] res_i,
  input  wire logic [2:0]  class_i,
  input  wire logic [9:0]  pwr_i,
  output logic             meas_done_o,
  output logic             meas_short_o,
  output logic [10:0]      meas_res_o,
  output logic [2:0]       meas_class_o,
  output logic [9:0]       meas_pwr_o
);
  logic [3:0] cnt_q;
  logic       hold_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 4'h0;
      hold_q <= 1'b0;
      meas_done_o <= 1'b0;
    end else begin
      meas_done_o <= 1'b0;
      cnt_q <= 4'h0;
      if (!meas_req_i)
        hold_q <= 1'b0;
      else if (!hold_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == lat_i) begin
          meas_done_o <= 1'b1;
          hold_q <= 1'b1;
        end
      end
    end
  end
  // Results only valid with done, garbage otherwise
  assign meas_short_o = meas_done_o ? short_i && meas_kind_i == MK_FCUR
                                    : !short_i;
  assign meas_res_o = meas_done_o ? res_i : ~res_i;
  assign meas_class_o = meas_done_o ? class_i : ~class_i;
  assign meas_pwr_o = meas_done_o ? pwr_i : ~pwr_i;
endmodule : psq_meas_model

// >>> test_psq_top.sv
// Testbench for the port mode sequencer
`timescale 1ns/1ps
module test_psq_top;
  import psq_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, rst_pin_n;
  logic        auto_pin, mid_pin, plo, phi, mreq, mdone, mshort, ext_en, sh;
  logic [7:0]  paddr, ilim, disc, pin_on;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] res, mres;
  logic [9:0]  pw, mpwr;
  logic [2:0]  mport, cls, mclass;
  logic [3:0]  lat;
  logic [79:0] icut, ilim_ma;
  psq_kind_t   mkind, last_kind;
  int          err_total, checked, n_meas;
  logic [10:0] rv [5] = '{11'h0fa, 11'h0fa, 11'h064, 11'h12c, 11'h258};
  logic [2:0]  dv [5] = '{DR_SHORT, DR_GOOD, DR_LOW, DR_HIGH, DR_OPEN};
  psq_top #(.BACKOFF_CYC(20), .MID_BACKOFF_CYC(40)) i_psq_top (
    .clk_sys_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .reset_pin_n_i(rst_pin_n),
    .standalone_sel_i(auto_pin), .midspan_sel_i(mid_pin),
    .power_limit_select_lo_i(plo), .power_limit_select_hi_i(phi),
    .port_ilim_fault_i(ilim), .port_disconnect_i(disc), .meas_req_o(mreq),
    .meas_port_o(mport), .meas_kind_o(mkind), .meas_done_i(mdone),
    .meas_short_i(mshort), .meas_res_i(mres), .meas_class_i(mclass),
    .meas_pwr_i(mpwr), .port_output_pin_o(pin_on), .port_icut_ma_o(icut),
    .port_ilim_ma_o(ilim_ma), .ext_power_en_o(ext_en));
  psq_meas_model i_psq_meas_model (
    .clk_sys_i(clk), .sys_rst_i(rst), .meas_req_i(mreq), .meas_kind_i(mkind),
    .lat_i(lat), .short_i(sh), .res_i(res), .class_i(cls), .pwr_i(pw),
    .meas_done_o(mdone), .meas_short_o(mshort), .meas_res_o(mres),
    .meas_class_o(mclass), .meas_pwr_o(mpwr));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (mreq === 1'b1 && mdone === 1'b1) begin
      n_meas++;
      last_kind = mkind;
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do @(negedge clk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      give_verdict();
    end
    @(posedge clk);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic strap_wait();
    rd = '0;
    for (int n = 0; n < 30 && rd[2:1] == 2'b00; n++)
      apb(1'b0, OFF_STRAP, 32'h0, rd);
  endtask : strap_wait
  initial begin
    {rst, psel, penable, pwrite, rst_pin_n, sh} = 6'b100010;
    {auto_pin, mid_pin, plo, phi, paddr, pwdata} = '0;
    {ilim, disc, res, pw, cls, lat} = {16'h0, 11'h0fa, 10'h0c8, 7'h43};
    {err_total, checked, n_meas} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    strap_wait();
    chk(rd[0], 1'b0);
    apb(1'b1, OFF_CTRL, 32'h6, rd);
    apb(1'b0, OFF_CTRL, 32'h0, rd);
    chk({rd[2:1], ext_en}, 3'b111);
    apb(1'b1, OFF_CTRL, 32'h2, rd);
    apb(1'b0, OFF_CTRL, 32'h0, rd);
    chk({rd[2:1], ext_en}, 3'b010);
    apb(1'b0, 8'h18, 32'h0, rd);
    chk(rd, 32'h0);
    apb(1'b1, OFF_CMD, 32'h0002_0002, rd);
    repeat (20) @(posedge clk);
    apb(1'b0, OFF_PWR, 32'h0, rd);
    chk({n_meas[7:0], rd[7:0]}, 16'h0);
    apb(1'b1, OFF_MODE, 32'h1, rd);
    for (int i = 0; i < 5; i++) begin
      sh <= (i == 0);
      res <= rv[i];
      n_meas = 0;
      apb(1'b1, OFF_CMD, 32'h1, rd);
      rd = '0;
      for (int n = 0; n < 40 && rd[2:0] !== dv[i]; n++)
        apb(1'b0, OFF_RES0, 32'h0, rd);
      repeat (20) @(posedge clk);
      chk(rd[2:0], dv[i]);
      chk(n_meas, 32'(i == 1) + 32'h1);
      chk(last_kind, i == 1 ? MK_FVOLT : MK_FCUR);
    end
    apb(1'b1, OFF_CMD, 32'h0001_0000, rd);
    disc <= 8'h01;
    apb(1'b0, OFF_PWR, 32'h0, rd);
    chk(rd[7:0], 8'h01);
    apb(1'b1, OFF_ENAB, 32'h0001_0000, rd);
    apb(1'b0, OFF_PWR, 32'h0, rd);
    chk(rd[7:0], 8'h00);
    disc <= 8'h00;
    apb(1'b1, OFF_CMD, 32'h0001_0000, rd);
    ilim <= 8'h01;
    apb(1'b0, OFF_PWR, 32'h0, rd);
    chk(rd[7:0], 8'h00);
    ilim <= 8'h00;
    apb(1'b1, OFF_ENAB, 32'h0001_0004, rd);
    apb(1'b1, OFF_MODE, 32'h21, rd);
    n_meas = 0;
    repeat (300) @(posedge clk);
    apb(1'b0, OFF_PWR, 32'h0, rd);
    chk({32'(n_meas > 3), rd[7:0]}, {32'h1, 8'h00});
    res <= 11'h0fa;
    for (int n = 0; n < 10 && rd[2] !== 1'b1; n++) begin
      apb(1'b1, OFF_CMD, 32'h0004_0000, rd);
      apb(1'b0, OFF_PWR, 32'h0, rd);
    end
    chk(rd[7:0], 8'h04);
    {auto_pin, plo, phi} <= 3'b111;
    rst_pin_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_pin_n <= 1'b1;
    strap_wait();
    chk({rd[13:4], rd[0]}, {PWR_L3, 1'b1});
    {plo, phi} <= 2'b00;
    apb(1'b0, OFF_STRAP, 32'h0, rd);
    chk({rd[13:4], rd[0]}, {PWR_L3, 1'b1});
    for (int n = 0; n < 3000 && pin_on !== 8'hff; n++) @(posedge clk);
    chk(pin_on, 8'hff);
    chk({icut[79:70], ilim_ma[9:0]}, {ICUT_C4, ILIM_C4});
    pw <= 10'h190;
    rst_pin_n <= 1'b0;
    repeat (12) @(posedge clk);
    chk(pin_on, 8'h00);
    rst_pin_n <= 1'b1;
    strap_wait();
    chk(rd[13:4], PWR_L0);
    repeat (400) @(posedge clk);
    chk(pin_on, 8'h00);
    give_verdict();
  end
endmodule : test_psq_top
